// *** ssq_frame_sequencer.v ***
// ssq_frame_sequencer.v: serial frame sequencer of an 8-channel sar converter
// assumes an ahb-lite master on sys_clk and a host driving the serial pins
//
// Notes on behaviour
// - every exchange is eight serial clock cycles
// - one conversion spans three transfers, 24 clocks
// - acquisition starts once multiplexer bits are known
// - three clocks later hold and convert
// - conversion takes the following sixteen serial clocks
// - control byte picks single-ended or differential input
// - sixteen-bit result, lsb is reference over 65536
// - input ignored until first high start bit
// - byte order start, channel, spare, mode, power
// - power field: 11 always on, 00 sleep between
// - busy one clock, then sixteen result bits out
`timescale 1ns/1ps
`include "ssq_map.vh"
module ssq_frame_sequencer (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        serial_clock_pin,
  input  wire        chip_select_n,
  input  wire        serial_in_pin,
  output reg         serial_out_pin,
  output reg         serial_out_oe,
  output reg         busy_pin,
  output reg         busy_oe,
  output reg  [2:0]  channel_select_field,
  output reg         input_mode_bit,
  output reg         sample_active,
  output reg         hold_active,
  output reg         converter_powered
);
  wire [2:0] pins_sync;
  reg        sclk_prev;
  // the host's serial clock is only sampled, never generated here
  ssq_pin_sync #(.WIDTH(3)) u_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    // select is inverted so that the reset value of the flops reads as deselected
    .pin_async ({serial_in_pin, ~chip_select_n, serial_clock_pin}),
    .pin_sync  (pins_sync)
  );
  wire s_sclk = pins_sync[0];
  wire s_cs   = pins_sync[1];
  wire s_din  = pins_sync[2];

  // register file
  reg        enable;
  reg [15:0] result_code;
  reg [15:0] conv_count;
  reg [7:0]  ctrl_byte;
  reg        int_clock_mode;
  reg        addr_wr;
  reg [7:0]  addr_q;

  wire sclk_rise = s_sclk & ~sclk_prev;
  wire sclk_fall = ~s_sclk & sclk_prev;
  wire cs_act    = s_cs & enable;

  // frame state
  reg        rx_active;
  reg [2:0]  rx_cnt;
  reg [6:0]  rx_sr;
  reg        conv_pend;
  reg        cv_active;
  reg [3:0]  cv_cnt;
  reg [15:0] cv_shift;
  wire [7:0] next_byte = {rx_sr, s_din};
  wire [1:0] next_pd   = next_byte[`SSQ_CB_PD_MSB:`SSQ_CB_PD_LSB];
  reg        pd_always_on;

  wire access = hsel & hready & htrans[1];

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      addr_wr   <= 1'b0;
      addr_q    <= 8'h00;
      enable    <= `SSQ_CTRL_RESET;
      result_code <= `SSQ_RESULT_RESET;
    end else begin
      // zero wait states, always okay
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      addr_wr   <= access & hwrite;
      addr_q    <= haddr[7:0];
      if (addr_wr) begin
        case (addr_q)
          `SSQ_ADDR_CTRL:   enable <= hwdata[`SSQ_CTRL_EN_BIT];
          `SSQ_ADDR_RESULT: result_code <= hwdata[15:0];
          default: ;
        endcase
      end
      // read data captured at the address phase edge
      if (access & ~hwrite) begin
        case (haddr[7:0])
          `SSQ_ADDR_CTRL:   hrdata <= {31'h00000000, enable};
          `SSQ_ADDR_RESULT: hrdata <= {16'h0000, result_code};
          `SSQ_ADDR_STATUS: hrdata <= {19'h00000, converter_powered, int_clock_mode,
                                       hold_active, sample_active, busy_pin, ctrl_byte};
          `SSQ_ADDR_COUNT:  hrdata <= {16'h0000, conv_count};
          default:          hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev            <= 1'b0;
      rx_active            <= 1'b0;
      rx_cnt               <= 3'd0;
      rx_sr                <= 7'h00;
      conv_pend            <= 1'b0;
      cv_active            <= 1'b0;
      cv_cnt               <= 4'h0;
      cv_shift             <= 16'h0000;
      ctrl_byte            <= 8'h00;
      conv_count           <= 16'h0000;
      int_clock_mode       <= 1'b0;
      pd_always_on         <= 1'b0;
      serial_out_pin       <= 1'b0;
      serial_out_oe        <= 1'b0;
      busy_pin             <= 1'b0;
      busy_oe              <= 1'b0;
      channel_select_field <= 3'd0;
      input_mode_bit       <= 1'b0;
      sample_active        <= 1'b0;
      hold_active          <= 1'b0;
      converter_powered    <= 1'b0;
    end else begin
      sclk_prev     <= s_sclk;
      serial_out_oe <= cs_act;
      busy_oe       <= cs_act;
      // sleeps between conversions unless always-on was chosen
      converter_powered <= pd_always_on | sample_active | hold_active | conv_pend;
      if (!cs_act) begin
        // chip select released: abandon any frame, busy reads low next time
        rx_active      <= 1'b0;
        rx_cnt         <= 3'd0;
        conv_pend      <= 1'b0;
        cv_active      <= 1'b0;
        busy_pin       <= 1'b0;
        serial_out_pin <= 1'b0;
        sample_active  <= 1'b0;
        hold_active    <= 1'b0;
      end else if (sclk_rise) begin
        // control bits taken on rising edges
        if (!rx_active) begin
          if (s_din) begin
            rx_active <= 1'b1;
            rx_cnt    <= 3'd1;
            rx_sr     <= 7'h01;
          end
        end else begin
          rx_sr  <= next_byte[6:0];
          rx_cnt <= rx_cnt + 3'd1;
          if (rx_cnt == `SSQ_ACQ_AFTER_BITS) begin
            // start and channel bits are in: set mux, begin sampling
            // fifth bit just arrived: channel sits one place above it
            channel_select_field <= next_byte[3:1];
            sample_active        <= 1'b1;
            hold_active          <= 1'b0;
          end
          if (rx_cnt == `SSQ_LAST_CTRL_CNT) begin
            rx_active      <= 1'b0;
            ctrl_byte      <= next_byte;
            input_mode_bit <= next_byte[`SSQ_CB_MODE_BIT];
            sample_active  <= 1'b0;
            hold_active    <= 1'b1;
            conv_pend      <= 1'b1;
            if (next_pd == `SSQ_PD_ALWAYS_ON) begin
              pd_always_on   <= 1'b1;
              int_clock_mode <= 1'b0;
            end else if (next_pd == `SSQ_PD_INT_CLOCK) begin
              pd_always_on   <= 1'b0;
              int_clock_mode <= 1'b1;
            end else if (next_pd == `SSQ_PD_BETWEEN) begin
              // clock mode is kept across power-down
              pd_always_on <= 1'b0;
            end
          end
        end
      end else if (sclk_fall) begin
        if (conv_pend) begin
          // msb decision cycle
          busy_pin  <= 1'b1;
          conv_pend <= 1'b0;
          cv_active <= 1'b1;
          cv_cnt    <= 4'h0;
          cv_shift  <= result_code;
        end else if (cv_active) begin
          busy_pin       <= 1'b0;
          serial_out_pin <= cv_shift[15];
          cv_shift       <= {cv_shift[14:0], 1'b0};
          cv_cnt         <= cv_cnt + 4'h1;
          if (cv_cnt == `SSQ_LAST_RES_CNT) begin
            // next byte may already be arriving; zeros follow the lsb
            cv_active   <= 1'b0;
            hold_active <= 1'b0;
            conv_count  <= conv_count + 16'h0001;
          end
        end else begin
          busy_pin       <= 1'b0;
          serial_out_pin <= 1'b0;
        end
      end
    end
  end
endmodule // ssq_frame_sequencer

// *** ssq_map.vh ***
// ssq_map.vh: register offsets, field positions, reset values and counts
// for the serial frame sequencer; included by ssq_frame_sequencer.v
`ifndef SSQ_MAP_VH
`define SSQ_MAP_VH

// register byte offsets, one aligned 32-bit word each
`define SSQ_ADDR_CTRL      8'h00
`define SSQ_ADDR_RESULT    8'h04
`define SSQ_ADDR_STATUS    8'h08
`define SSQ_ADDR_COUNT     8'h0c

// control register fields and reset value, result register reset value
`define SSQ_CTRL_EN_BIT    0
`define SSQ_CTRL_RESET     1'b1
`define SSQ_RESULT_RESET   16'h0000

// status register field positions
`define SSQ_ST_BYTE_LSB    0
`define SSQ_ST_BUSY_BIT    8
`define SSQ_ST_ACQ_BIT     9
`define SSQ_ST_HOLD_BIT    10
`define SSQ_ST_INTCLK_BIT  11
`define SSQ_ST_PWR_BIT     12

// control byte layout
`define SSQ_CB_CH_MSB      6
`define SSQ_CB_CH_LSB      4
`define SSQ_CB_MODE_BIT    2
`define SSQ_CB_PD_MSB      1
`define SSQ_CB_PD_LSB      0
`define SSQ_PD_ALWAYS_ON   2'b11
`define SSQ_PD_INT_CLOCK   2'b10
`define SSQ_PD_BETWEEN     2'b00

// frame counts in serial clock cycles and transfers
`define SSQ_BITS_PER_XFER  8
`define SSQ_XFERS_PER_CONV 3
`define SSQ_ACQ_AFTER_BITS 3'd4
`define SSQ_LAST_CTRL_CNT  3'd7
`define SSQ_RESULT_BITS    16
`define SSQ_LAST_RES_CNT   4'd15

`endif

// *** ssq_pin_sync.v ***
// ssq_pin_sync.v: two-flop synchroniser for pins from outside sys_clk
// assumes nothing of the pins but that they are plain levels
`timescale 1ns/1ps
module ssq_pin_sync #(
  parameter WIDTH = 3
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin_async,
  output wire [WIDTH-1:0] pin_sync
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // first stage feeds only the second stage
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i]   <= 1'b0;
          stable[i] <= 1'b0;
        end else begin
          meta[i]   <= pin_async[i];
          stable[i] <= meta[i];
        end
      end
    end
  endgenerate
  assign pin_sync = stable;
endmodule // ssq_pin_sync

// *** ssq_frame_chk.sv ***
// ssq_frame_chk.sv: port assertions of the frame sequencer
// assumes one sys_clk domain and a serial clock near 125 ns
`timescale 1ns/1ps
module ssq_frame_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire serial_clock_pin,
  input wire chip_select_n,
  input wire serial_out_pin,
  input wire serial_out_oe,
  input wire busy_pin,
  input wire busy_oe,
  input wire sample_active,
  input wire hold_active,
  input wire converter_powered
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // counts hold cycles; frames are only a few hundred cycles long
  reg [8:0] hold_cnt;
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n) hold_cnt <= 9'h000;
    else hold_cnt <= hold_active ? hold_cnt + 9'h001 : 9'h000;
  acq_hold_excl_a:
    assert property (!(sample_active && hold_active)) else $error("acq with hold");
  hold_after_acq_a:
    assert property ($fell(sample_active) && !chip_select_n |-> hold_active) else $error("no hold");
  busy_width_a:
    assert property ($rose(busy_pin) |-> busy_pin [*8] ##[1:8] !busy_pin) else $error("busy width");
  busy_in_hold_a:
    assert property ($rose(busy_pin) |-> hold_active) else $error("busy out of hold");
  out_on_fall_a:
    assert property ($changed(serial_out_pin) |-> !serial_clock_pin) else $error("out on rise");
  oe_pair_a:
    assert property (busy_oe == serial_out_oe && (busy_oe || !busy_pin)) else $error("oe mismatch");
  conv_len_a:
    assert property ($fell(hold_active) && !chip_select_n |-> hold_cnt inside {[9'h0c8:9'h0d4]})
      else $error("hold length");
  hold_power_a:
    assert property (hold_active |-> converter_powered) else $error("hold unpowered");
  busy_c: cover property ($rose(busy_pin));
  conv_c: cover property ($fell(hold_active));
  acq_c: cover property ($rose(sample_active));
endmodule // ssq_frame_chk
bind ssq_frame_sequencer ssq_frame_chk ssq_frame_chk_i (.*);

// *** ssq_host_model.sv ***
// ssq_host_model.sv: host serial port, sends control bytes, reads results
// assumes the device samples rising edges and shifts out on falling ones
`timescale 1ns/1ps
module ssq_host_model (
  output logic serial_clock_pin,
  output logic chip_select_n,
  output logic serial_in_pin,
  input  wire  serial_out_pin
);
  logic [15:0] got;
  initial begin
    serial_clock_pin = 1'b0;
    chip_select_n = 1'b1;
    serial_in_pin = 1'b0;
  end
  // clock idles low; one extra cycle catches the last bit
  task automatic frame(input logic [7:0] cb, input int pre);
    // offset keeps every pin change clear of the sys_clk rising edges
    #6.25 chip_select_n = 1'b0;
    for (int k = 0; k < pre + 25; k++) begin
      #40 serial_in_pin = (k >= pre && k < pre + 8) ? cb[7 - k + pre] : 1'b0;
      #22.5 serial_clock_pin = 1'b1;
      if (k > pre + 8) got = {got[14:0], serial_out_pin};
      #62.5 serial_clock_pin = 1'b0;
    end
    #40 chip_select_n = 1'b1;
    serial_in_pin = ~serial_in_pin;
  endtask
  // stops after n control bits, chip select left low
  task automatic part(input logic [7:0] cb, input int n);
    #6.25 chip_select_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      #40 serial_in_pin = cb[7 - k];
      #22.5 serial_clock_pin = 1'b1;
      #62.5 serial_clock_pin = 1'b0;
    end
  endtask
  task automatic drop;
    #41.25 chip_select_n = 1'b1;
  endtask
endmodule // ssq_host_model

// *** testbench.sv ***
// testbench.sv: register and frame tests of the sequencer
// assumes the host model on the serial pins and ahb-lite on sys_clk
`timescale 1ns/1ps
`include "ssq_map.vh"
module testbench;
  logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire         hready, hreadyout, hresp, serial_clock_pin, chip_select_n, serial_in_pin;
  wire         serial_out_pin, serial_out_oe, busy_pin, busy_oe, input_mode_bit;
  wire         sample_active, hold_active, converter_powered;
  wire  [2:0]  channel_select_field;
  wire  [31:0] hrdata;
  int          failures = 0, num_checks = 0;
  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;
  ssq_frame_sequencer ssq_frame_sequencer_i (.*);
  ssq_host_model ssq_host_model_i (.*);
  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string n, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic test_regs;
    rchk("ctrl", `SSQ_ADDR_CTRL, 32'h1);
    rchk("result", `SSQ_ADDR_RESULT, 32'h0);
    rchk("count", `SSQ_ADDR_COUNT, 32'h0);
    rchk("unmapped", 32'h10, 32'h0);
    $display("test_regs done");
  endtask
  task test_frames;
    logic [7:0]  cb [4] = '{8'h97, 8'he0, 8'hd2, 8'ha5};
    logic [15:0] res [4] = '{16'ha5c3, 16'h0001, 16'h8000, 16'hffff};
    logic        pwr [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    logic        icm [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `SSQ_ADDR_RESULT, 32'(res[i]));
      ssq_host_model_i.frame(cb[i], i);
      repeat (5) @(posedge sys_clk);
      chk("result bits", 32'(res[i]), 32'(ssq_host_model_i.got));
      chk("channel", 32'(cb[i][6:4]), 32'(channel_select_field));
      chk("mode", 32'(cb[i][2]), 32'(input_mode_bit));
      chk("powered", 32'(pwr[i]), 32'(converter_powered));
      bus(1'b0, `SSQ_ADDR_STATUS, 32'h0);
      chk("ctrl byte", 32'(cb[i]), 32'(rd[7:0]));
      chk("int clock", 32'(icm[i]), 32'(rd[`SSQ_ST_INTCLK_BIT]));
      chk("flags", 32'h0, 32'(rd[`SSQ_ST_HOLD_BIT:`SSQ_ST_BUSY_BIT]));
      rchk("count", `SSQ_ADDR_COUNT, 32'(i + 1));
    end
    $display("test_frames done");
  endtask
  task automatic test_cut;
    ssq_host_model_i.part(8'hb7, 6);
    repeat (5) @(posedge sys_clk);
    chk("acquiring", 32'h1, 32'(sample_active));
    chk("hold early", 32'h0, 32'(hold_active));
    chk("cut channel", 32'h3, 32'(channel_select_field));
    chk("out enable", 32'h1, 32'(serial_out_oe));
    chk("busy enable", 32'h1, 32'(busy_oe));
    ssq_host_model_i.drop;
    repeat (5) @(posedge sys_clk);
    chk("acq dropped", 32'h0, 32'(sample_active));
    chk("oe dropped", 32'h0, 32'(serial_out_oe | busy_oe));
    bus(1'b0, `SSQ_ADDR_STATUS, 32'h0);
    chk("byte kept", 32'ha5, 32'(rd[7:0]));
    rchk("count kept", `SSQ_ADDR_COUNT, 32'h4);
    $display("test_cut done");
  endtask
  task automatic test_off;
    bus(1'b1, `SSQ_ADDR_CTRL, 32'h0);
    rchk("ctrl off", `SSQ_ADDR_CTRL, 32'h0);
    ssq_host_model_i.frame(8'hc3, 0);
    repeat (5) @(posedge sys_clk);
    chk("off result", 32'h0, 32'(ssq_host_model_i.got));
    chk("off channel", 32'h3, 32'(channel_select_field));
    rchk("off count", `SSQ_ADDR_COUNT, 32'h4);
    bus(1'b1, `SSQ_ADDR_CTRL, 32'h1);
    rchk("ctrl on", `SSQ_ADDR_CTRL, 32'h1);
    $display("test_off done");
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    test_regs;
    test_frames;
    test_cut;
    test_off;
    close_out;
  end
  // frames take about 3.2 to 3.5 us each
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule // testbench
